// ==== src/qpiw_pkg.sv ====
// Shared constants of the flash-bank wake and second-core status registers.
// Assumes an 8-bit byte address and a 32-bit register data path.
package qpiw_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	// Four conditions per pin, six pins
	localparam int PIN_COUNT = 6;
	localparam int COND_PER_PIN = 4;
	localparam int COND_W = PIN_COUNT * COND_PER_PIN;
	// Condition order inside one pin nibble
	localparam int COND_LEVEL_LOW = 0;
	localparam int COND_LEVEL_HIGH = 1;
	localparam int COND_EDGE_LOW = 2;
	localparam int COND_EDGE_HIGH = 3;
	// Pin order, one nibble each from bit 0
	localparam int PIN_CLOCK = 0;
	localparam int PIN_SELECT = 1;
	localparam int PIN_DATA0 = 2;
	localparam int PIN_DATA1 = 3;
	localparam int PIN_DATA2 = 4;
	localparam int PIN_DATA3 = 5;
	// Register offsets
	localparam logic [ADDR_W-1:0] OFF_SECOND_CORE_IRQ_STATUS = 8'h48;
	localparam logic [ADDR_W-1:0] OFF_WAKE_IRQ_ENABLE = 8'h4c;
	localparam logic [ADDR_W-1:0] OFF_WAKE_IRQ_FORCE = 8'h50;
	localparam logic [ADDR_W-1:0] OFF_WAKE_IRQ_STATUS = 8'h54;
	localparam logic [ADDR_W-1:0] OFF_EVENT_STATUS = 8'h58;
	localparam logic [ADDR_W-1:0] OFF_EVENT_MASK = 8'h5c;
	// Reset values
	localparam logic [COND_W-1:0] RST_WAKE_IRQ_ENABLE = 24'h00_0000;
	localparam logic [COND_W-1:0] RST_WAKE_IRQ_FORCE = 24'h00_0000;
	localparam logic [COND_W-1:0] RST_STATUS = 24'h00_0000;
	// Sticky event bits
	localparam int EVT_COUNT = 2;
	localparam int EVT_SECOND_CORE = 0;
	localparam int EVT_WAKE = 1;
	localparam logic [EVT_COUNT-1:0] RST_EVENT = 2'h0;
	localparam logic [DATA_W-1:0] READ_ZERO = 32'h0000_0000;
endpackage

// ==== src/qpiw_fold.sv ====
// Gate-and-force fold of a condition vector into a registered status word.
// Assumes all inputs come from logic on ref_clk.
`timescale 1ns/1ps
module qpiw_fold #(
	parameter int WIDTH = 24
) (
	input wire logic ref_clk, // System clock
	input wire logic rst, // Async reset, high
	input wire logic [WIDTH-1:0] rawCond, // Raw conditions
	input wire logic [WIDTH-1:0] enable, // Per-bit enable
	input wire logic [WIDTH-1:0] force_, // Per-bit force
	output logic [WIDTH-1:0] status_r, // Folded status
	output logic anyHit_r // Any status bit set
);
	import qpiw_pkg::*;

	logic [WIDTH-1:0] status_nxt;
	logic anyHit_nxt;

	always_comb begin
		status_nxt = (rawCond & enable) | force_;
		anyHit_nxt = |status_nxt;
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			status_r <= '0;
			anyHit_r <= 1'b0;
		end else begin
			status_r <= status_nxt;
			anyHit_r <= anyHit_nxt;
		end
	end
endmodule

// ==== src/qpiw_evt.sv ====
// Sticky event status with write-one-to-clear, mask and level interrupt.
// Assumes event pulses and bus strobes are on ref_clk.
`timescale 1ns/1ps
module qpiw_evt #(
	parameter int N = 2
) (
	input wire logic ref_clk, // System clock
	input wire logic rst, // Async reset, high
	input wire logic [N-1:0] evtIn, // One-cycle event pulses
	input wire logic clrWr, // Write to status
	input wire logic maskWr, // Write to mask
	input wire logic [N-1:0] wrBits, // Write data bits
	output logic [N-1:0] status_r, // Sticky status
	output logic [N-1:0] mask_r, // Interrupt mask
	output logic irq_r // Level interrupt
);
	import qpiw_pkg::*;

	logic [N-1:0] status_nxt;
	logic [N-1:0] mask_nxt;
	logic irq_nxt;

	always_comb begin
		status_nxt = status_r;
		if (clrWr) begin
			status_nxt = status_nxt & ~wrBits;
		end
		// Set wins over a clear in the same cycle
		status_nxt = status_nxt | evtIn;
		mask_nxt = maskWr ? wrBits : mask_r;
		irq_nxt = |(status_nxt & mask_nxt);
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			status_r <= '0;
			mask_r <= '0;
			irq_r <= 1'b0;
		end else begin
			status_r <= status_nxt;
			mask_r <= mask_nxt;
			irq_r <= irq_nxt;
		end
	end
endmodule

// ==== src/qpiw_regs.sv ====
// Second-core status and deep-sleep wake registers of the flash pin bank.
// Assumes raw conditions and second-core enable/force come from ref_clk logic.
//
// Notes on behaviour
// - second-core status is raw AND enable, OR force
// - wake enable word, read/write, resets to zero
// - wake force word asserts conditions, resets zero
// - wake status is raw AND enable, OR force
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
module qpiw_regs (
	input wire logic ref_clk, // System clock, 100 MHz
	input wire logic rst, // Async reset, high
	input wire logic [qpiw_pkg::ADDR_W-1:0] addr, // Byte address
	input wire logic [qpiw_pkg::DATA_W-1:0] wrData, // Write data
	input wire logic wrEn, // Write strobe
	input wire logic rdEn, // Read strobe
	output logic [qpiw_pkg::DATA_W-1:0] rdData_r, // Read data, next cycle
	input wire logic [qpiw_pkg::COND_W-1:0] rawCond, // Raw pin conditions
	input wire logic [qpiw_pkg::COND_W-1:0] secondCoreEnable, // Second-core enable
	input wire logic [qpiw_pkg::COND_W-1:0] secondCoreForce, // Second-core force
	output logic secondCoreIrq, // Second-core request
	output logic wakeReq, // Deep-sleep wake request
	output logic irq_r // Event interrupt
);
	import qpiw_pkg::*;

	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
		hit = (a == off);
	endfunction

	// Widen a condition word to the bus, top byte zero
	function automatic logic [DATA_W-1:0] widen(input logic [COND_W-1:0] v);
		widen = {{(DATA_W - COND_W){1'b0}}, v};
	endfunction

	logic [COND_W-1:0] wakeEnable_r;
	logic [COND_W-1:0] wakeEnable_nxt;
	logic [COND_W-1:0] wakeForce_r;
	logic [COND_W-1:0] wakeForce_nxt;
	logic [COND_W-1:0] secondCoreStatus;
	logic [COND_W-1:0] wakeStatus;
	logic secondCoreAny;
	logic wakeAny;
	logic secondCoreAnyPrev_r;
	logic wakeAnyPrev_r;
	logic [EVT_COUNT-1:0] evtPulse;
	logic [EVT_COUNT-1:0] evtStatus;
	logic [EVT_COUNT-1:0] evtMask;
	logic evtClrWr;
	logic evtMaskWr;
	logic [DATA_W-1:0] rdData_nxt;

	// Register writes
	always_comb begin
		wakeEnable_nxt = wakeEnable_r;
		wakeForce_nxt = wakeForce_r;
		if (wrEn && hit(addr, OFF_WAKE_IRQ_ENABLE)) begin
			wakeEnable_nxt = wrData[COND_W-1:0];
		end
		if (wrEn && hit(addr, OFF_WAKE_IRQ_FORCE)) begin
			wakeForce_nxt = wrData[COND_W-1:0];
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			wakeEnable_r <= RST_WAKE_IRQ_ENABLE;
			wakeForce_r <= RST_WAKE_IRQ_FORCE;
		end else begin
			wakeEnable_r <= wakeEnable_nxt;
			wakeForce_r <= wakeForce_nxt;
		end
	end

	qpiw_fold #(
		.WIDTH(COND_W)
	) u_secondCoreFold (
		.ref_clk(ref_clk),
		.rst(rst),
		.rawCond(rawCond),
		.enable(secondCoreEnable),
		.force_(secondCoreForce),
		.status_r(secondCoreStatus),
		.anyHit_r(secondCoreAny)
	);

	qpiw_fold #(
		.WIDTH(COND_W)
	) u_wakeFold (
		.ref_clk(ref_clk),
		.rst(rst),
		.rawCond(rawCond),
		.enable(wakeEnable_r),
		.force_(wakeForce_r),
		.status_r(wakeStatus),
		.anyHit_r(wakeAny)
	);

	assign secondCoreIrq = secondCoreAny;
	assign wakeReq = wakeAny;

	// Rising request edges become sticky events
	always_comb begin
		evtPulse = '0;
		evtPulse[EVT_SECOND_CORE] = secondCoreAny & ~secondCoreAnyPrev_r;
		evtPulse[EVT_WAKE] = wakeAny & ~wakeAnyPrev_r;
		evtClrWr = wrEn && hit(addr, OFF_EVENT_STATUS);
		evtMaskWr = wrEn && hit(addr, OFF_EVENT_MASK);
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			secondCoreAnyPrev_r <= 1'b0;
			wakeAnyPrev_r <= 1'b0;
		end else begin
			secondCoreAnyPrev_r <= secondCoreAny;
			wakeAnyPrev_r <= wakeAny;
		end
	end

	qpiw_evt #(
		.N(EVT_COUNT)
	) u_evt (
		.ref_clk(ref_clk),
		.rst(rst),
		.evtIn(evtPulse),
		.clrWr(evtClrWr),
		.maskWr(evtMaskWr),
		.wrBits(wrData[EVT_COUNT-1:0]),
		.status_r(evtStatus),
		.mask_r(evtMask),
		.irq_r(irq_r)
	);

	// Read mux; data valid only the cycle after the strobe
	always_comb begin
		rdData_nxt = READ_ZERO;
		if (rdEn) begin
			case (addr)
				OFF_SECOND_CORE_IRQ_STATUS: begin
					rdData_nxt = widen(secondCoreStatus);
				end
				OFF_WAKE_IRQ_ENABLE: begin
					rdData_nxt = widen(wakeEnable_r);
				end
				OFF_WAKE_IRQ_FORCE: begin
					rdData_nxt = widen(wakeForce_r);
				end
				OFF_WAKE_IRQ_STATUS: begin
					rdData_nxt = widen(wakeStatus);
				end
				OFF_EVENT_STATUS: begin
					rdData_nxt = {{(DATA_W - EVT_COUNT){1'b0}}, evtStatus};
				end
				OFF_EVENT_MASK: begin
					rdData_nxt = {{(DATA_W - EVT_COUNT){1'b0}}, evtMask};
				end
				default: begin
					rdData_nxt = READ_ZERO;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			rdData_r <= READ_ZERO;
		end else begin
			rdData_r <= rdData_nxt;
		end
	end
endmodule

// ==== verif/qpiw_regs_monitor.sv ====
// Port checker for the wake and second-core status registers.
// Assumes it is bound to qpiw_regs and sees only its ports.
`timescale 1ns/1ps
module qpiw_regs_checker (
	input wire logic ref_clk, // Clock
	input wire logic rst, // Reset
	input wire logic [qpiw_pkg::ADDR_W-1:0] addr, // Address
	input wire logic rdEn, // Read strobe
	input wire logic [qpiw_pkg::DATA_W-1:0] rdData_r, // Read data
	input wire logic [qpiw_pkg::COND_W-1:0] rawCond, // Conditions
	input wire logic [qpiw_pkg::COND_W-1:0] secondCoreEnable, // Enable
	input wire logic [qpiw_pkg::COND_W-1:0] secondCoreForce, // Force
	input wire logic secondCoreIrq, // Core request
	input wire logic wakeReq // Wake request
);
	import qpiw_pkg::*;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	a_core_req_fold: assert property (
		!$past(rst) |-> secondCoreIrq == $past(|((rawCond & secondCoreEnable) | secondCoreForce)))
		else $error("core request not the folded conditions");
	a_core_read_req: assert property (
		$past(rdEn) && $past(addr) == OFF_SECOND_CORE_IRQ_STATUS
		|-> (|rdData_r) == $past(secondCoreIrq))
		else $error("core status read disagrees with request");
	a_wake_read_req: assert property (
		$past(rdEn) && $past(addr) == OFF_WAKE_IRQ_STATUS |-> (|rdData_r) == $past(wakeReq))
		else $error("wake status read disagrees with request");
	a_top_byte_zero: assert property (
		$past(rdEn) |-> rdData_r[31:24] == 8'h00)
		else $error("reserved byte not zero");
	a_read_one_cycle: assert property (
		!$past(rdEn) |-> rdData_r == READ_ZERO)
		else $error("read data outside its cycle");
endmodule
bind qpiw_regs qpiw_regs_checker u_mon (.ref_clk(ref_clk), .rst(rst), .addr(addr),
	.rdEn(rdEn), .rdData_r(rdData_r), .rawCond(rawCond), .secondCoreEnable(secondCoreEnable),
	.secondCoreForce(secondCoreForce), .secondCoreIrq(secondCoreIrq), .wakeReq(wakeReq));

// ==== verif/tb_qpiw_regs.sv ====
// Self-checking bench for the wake and second-core status registers.
// Assumes qpiw_regs alone, on a 100 MHz clock.
`timescale 1ns/1ps
module tb_qpiw_regs;
	import qpiw_pkg::*;
	logic ref_clk = 0;
	logic rst = 1;
	logic [ADDR_W-1:0] addr = '0;
	logic [DATA_W-1:0] wrData = '0;
	logic wrEn = 0;
	logic rdEn = 0;
	logic [COND_W-1:0] rawCond = '0;
	logic [COND_W-1:0] coreEn = '0;
	logic [COND_W-1:0] coreFrc = '0;
	logic [DATA_W-1:0] rdData_r;
	logic secondCoreIrq;
	logic wakeReq;
	logic irq_r;
	int mismatches = 0;
	int checks = 0;
	int cycles = 0;
	qpiw_regs dut (.ref_clk(ref_clk), .rst(rst), .addr(addr), .wrData(wrData), .wrEn(wrEn),
		.rdEn(rdEn), .rdData_r(rdData_r), .rawCond(rawCond), .secondCoreEnable(coreEn),
		.secondCoreForce(coreFrc), .secondCoreIrq(secondCoreIrq), .wakeReq(wakeReq),
		.irq_r(irq_r));
	initial forever #5 ref_clk = ~ref_clk;
	task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD t=%0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge ref_clk);
		addr <= a;
		wrData <= d;
		wrEn <= 1'b1;
		@(posedge ref_clk);
		wrEn <= 1'b0;
	endtask
	task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
		@(posedge ref_clk);
		addr <= a;
		rdEn <= 1'b1;
		@(posedge ref_clk);
		rdEn <= 1'b0;
		#1;
		chk(rdData_r, exp);
	endtask
	task automatic idle();
		repeat (3) @(posedge ref_clk);
	endtask
	task automatic t_reset();
		rd(8'h4c, 32'h0000_0000);
		rd(8'h50, 32'h0000_0000);
		rd(8'h54, 32'h0000_0000);
		rd(8'h48, 32'h0000_0000);
		rd(8'h60, 32'h0000_0000);
		chk({31'h0, secondCoreIrq}, 32'h0000_0000);
		chk({31'h0, wakeReq}, 32'h0000_0000);
		$display("reset test done");
	endtask
	task automatic t_wake();
		wr(8'h4c, 32'hFFA5_5A5A);
		@(posedge ref_clk) rawCond <= 24'h33_3333;
		rd(8'h4c, 32'h00A5_5A5A);
		idle();
		rd(8'h54, 32'h0021_1212);
		wr(8'h50, 32'hFF40_0004);
		wr(8'h54, 32'hFFFF_FFFF);
		idle();
		rd(8'h50, 32'h0040_0004);
		rd(8'h54, 32'h0061_1216);
		$display("wake test done");
	endtask
	task automatic t_core();
		@(posedge ref_clk) coreEn <= 24'hF0_000F;
		coreFrc <= 24'h00_0300;
		wr(8'h48, 32'hFFFF_FFFF);
		idle();
		rd(8'h48, 32'h0030_0303);
		chk({31'h0, secondCoreIrq}, 32'h0000_0001);
		$display("core test done");
	endtask
	task automatic t_layout();
		wr(8'h4c, 32'h00FF_FFFF);
		wr(8'h50, 32'h0000_0000);
		for (int i = 0; i < COND_W; i++) begin
			@(posedge ref_clk) rawCond <= 24'h00_0001 << i;
			idle();
			rd(8'h54, 32'h0000_0001 << i);
		end
		$display("layout test done");
	endtask
	task automatic t_event();
		wr(8'h4c, 32'h0000_0001);
		@(posedge ref_clk) rawCond <= '0;
		coreEn <= '0;
		coreFrc <= '0;
		idle();
		wr(8'h58, 32'h0000_0003);
		rd(8'h58, 32'h0000_0000);
		chk({31'h0, wakeReq}, 32'h0000_0000);
		chk({31'h0, secondCoreIrq}, 32'h0000_0000);
		@(posedge ref_clk) rawCond <= 24'h00_0001;
		idle();
		rd(8'h58, 32'h0000_0002);
		chk({31'h0, wakeReq}, 32'h0000_0001);
		chk({31'h0, irq_r}, 32'h0000_0000);
		wr(8'h5c, 32'h0000_0002);
		rd(8'h5c, 32'h0000_0002);
		chk({31'h0, irq_r}, 32'h0000_0001);
		wr(8'h58, 32'h0000_0002);
		rd(8'h58, 32'h0000_0000);
		chk({31'h0, irq_r}, 32'h0000_0000);
		$display("event test done");
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 2000) begin
			mismatches++;
			complete_run();
		end
	end
	initial begin
		repeat (6) @(posedge ref_clk);
		rst <= 1'b0;
		t_reset();
		t_wake();
		t_core();
		t_layout();
		t_event();
		complete_run();
	end
endmodule
